// ---- hw/eui_flags.v ----
// upper interrupt status flags with apb access, mask and reset watchdog
//
// Local design decisions: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`include "eui_map.vh"
module eui_flags #(
  parameter integer WDOG_CYCLES = `EUI_WDOG_CYCLES
) (
  input wire pclk,
  input wire presetn,
  // register bus
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  output wire [31:0] prdata,
  output wire pready,
  output wire pslverr,
  // event sources from the mac, fifo, usb and phy sides
  input wire phy_rx_clk_seen,
  // receive fifo write handshake
  input wire rx_fifo_full,
  input wire rx_write_req,
  output wire rx_write_accept,
  // same-domain status levels, plus phy_irq_n from another domain
  input wire tx_error,
  input wire usb_event_pending,
  input wire fifo_tx_disabled,
  input wire mac_transmit_reg_disabled,
  input wire fifo_rx_disabled,
  input wire mac_receive_reg_disabled,
  input wire phy_irq_n,
  input wire dport_done,
  // mac reset and interrupt outputs
  output wire mac_reset_n,
  output wire irq
);

  // pins from other domains pass two flops before any logic reads them;
  // reset levels match the idle pins, so no false event follows reset
  wire clk_seen;
  wire phy_irq_s;
  eui_sync #(
    .RST_LEVEL(1'b0)
  ) u_clk_seen_sync (
    .pclk(pclk),
    .presetn(presetn),
    .din(phy_rx_clk_seen),
    .dout(clk_seen)
  );
  eui_sync #(
    .RST_LEVEL(1'b1)
  ) u_phy_irq_sync (
    .pclk(pclk),
    .presetn(presetn),
    .din(phy_irq_n),
    .dout(phy_irq_s)
  );
  wire phy_level = ~phy_irq_s;

  // apb decode; zero wait states
  wire access = psel & penable;
  wire wr_en = access & pwrite;
  wire hit_status = (paddr == `EUI_STATUS_ADDR);
  wire hit_mask = (paddr == `EUI_MASK_ADDR);
  wire hit_ctrl = (paddr == `EUI_CTRL_ADDR);
  wire hit_any = hit_status | hit_mask | hit_ctrl;
  assign pready = 1'b1;
  assign pslverr = access & ~hit_any;

  // flag index inside the 8-bit field
  localparam integer IDX_DP = `EUI_BIT_DP - `EUI_FLAG_LO;
  localparam integer IDX_PHY = `EUI_BIT_PHY - `EUI_FLAG_LO;
  localparam integer IDX_RXDIS = `EUI_BIT_RXDIS - `EUI_FLAG_LO;
  localparam integer IDX_TXDIS = `EUI_BIT_TXDIS - `EUI_FLAG_LO;
  localparam integer IDX_USB = `EUI_BIT_USB - `EUI_FLAG_LO;
  localparam integer IDX_TXE = `EUI_BIT_TXE - `EUI_FLAG_LO;
  localparam integer IDX_RDFO = `EUI_BIT_RDFO - `EUI_FLAG_LO;
  localparam integer IDX_MACRTO = `EUI_BIT_MACRTO - `EUI_FLAG_LO;

  // watchdog states; done is terminal until the next reset
  localparam [1:0] WD_IDLE = 2'h0;
  localparam [1:0] WD_COUNT = 2'h1;
  localparam [1:0] WD_FIRE = 2'h2;
  localparam [1:0] WD_DONE = 2'h3;

  reg [7:0] flags;
  wire [7:0] next_flags;
  reg [7:0] mask;
  reg [7:0] next_mask;
  reg wdog_enable;
  reg next_wdog_enable;
  reg [1:0] wd_state;
  reg [1:0] next_wd_state;
  reg [31:0] wdog_count;
  reg [31:0] next_wdog_count;
  wire wdog_expired;
  wire wdog_pulse;
  reg dport_done_d;
  reg [31:0] rdata;
  reg [31:0] prdata_q;
  reg irq_q;

  // register write decode; mask uses byte lane 2, control uses lane 0
  always @* begin
    next_mask = mask;
    next_wdog_enable = wdog_enable;
    if (wr_en && hit_mask && pstrb[2]) begin
      next_mask = pwdata[`EUI_FLAG_HI:`EUI_FLAG_LO];
    end
    if (wr_en && hit_ctrl && pstrb[0]) begin
      next_wdog_enable = pwdata[0];
    end
  end

  // mask and control registers: control bit 0 starts the mac reset watchdog
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask <= `EUI_MASK_RESET;
      wdog_enable <= 1'b0;
    end else begin
      mask <= next_mask;
      wdog_enable <= next_wdog_enable;
    end
  end

  // watchdog next state: counts only while enabled and phy clocks are absent
  always @* begin
    next_wd_state = wd_state;
    next_wdog_count = wdog_count;
    case (wd_state)
      WD_IDLE: begin
        next_wdog_count = 32'h0;
        // the first counting edge already counts as one
        if (wdog_enable && !clk_seen) begin
          next_wd_state = WD_COUNT;
          next_wdog_count = 32'h1;
        end
      end
      WD_COUNT: begin
        if (!wdog_enable || clk_seen) begin
          // clocks came back or software gave up: start over next time
          next_wd_state = WD_IDLE;
          next_wdog_count = 32'h0;
        end else if (wdog_count >= WDOG_CYCLES - 1) begin
          next_wd_state = WD_FIRE;
        end else begin
          next_wdog_count = wdog_count + 32'h1;
        end
      end
      WD_FIRE: begin
        // one cycle only, so bit 23 latches a pulse, not a level
        next_wd_state = WD_DONE;
      end
      WD_DONE: begin
        // stays expired; only reset re-arms the watchdog
        next_wd_state = WD_DONE;
      end
      default: begin
        // unused code falls back to idle
        next_wd_state = WD_IDLE;
        next_wdog_count = 32'h0;
      end
    endcase
  end

  // watchdog state registers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wd_state <= WD_IDLE;
      wdog_count <= 32'h0;
    end else begin
      wd_state <= next_wd_state;
      wdog_count <= next_wdog_count;
    end
  end
  // expiry is sticky; a late clock arrival does not put the mac back in reset
  assign wdog_expired = (wd_state == WD_FIRE) || (wd_state == WD_DONE);
  assign wdog_pulse = (wd_state == WD_FIRE);

  // reset released by phy clocks or forced by expiry, no clock wait on expiry
  assign mac_reset_n = clk_seen | wdog_expired;

  // completion edge makes a single pulse even for a long done level;
  // a done level left high cannot re-set the flag after a clear
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dport_done_d <= 1'b0;
    end else begin
      dport_done_d <= dport_done;
    end
  end
  wire dport_pulse = dport_done & ~dport_done_d;

  wire overflow_evt = rx_write_req & rx_fifo_full;
  // held off while overflow flag stands; requests keep it set, so software clears it while rx_write_req is low to resume
  assign rx_write_accept = rx_write_req & ~rx_fifo_full & ~flags[IDX_RDFO];

  // event sources in bit order 16..23
  // pulse sources latch once; level sources set again every cycle they stand
  wire [7:0] set_vec;
  assign set_vec[IDX_DP] = dport_pulse;
  assign set_vec[IDX_PHY] = phy_level;
  assign set_vec[IDX_RXDIS] = fifo_rx_disabled | mac_receive_reg_disabled;
  assign set_vec[IDX_TXDIS] = fifo_tx_disabled | mac_transmit_reg_disabled;
  assign set_vec[IDX_USB] = usb_event_pending;
  assign set_vec[IDX_TXE] = tx_error;
  assign set_vec[IDX_RDFO] = overflow_evt | (rx_write_req & flags[IDX_RDFO]);
  assign set_vec[IDX_MACRTO] = wdog_pulse;

  // write-one clear through byte lane 2
  wire [7:0] clr_vec = (wr_en && hit_status && pstrb[2]) ?
    pwdata[`EUI_FLAG_HI:`EUI_FLAG_LO] : 8'h00;

  // per-flag next value: set wins over a write-one clear in the same cycle,
  // so an event arriving during the clear is never lost
  genvar i;
  generate
    for (i = 0; i < 8; i = i + 1) begin : g_flag
      assign next_flags[i] = set_vec[i] | (flags[i] & ~clr_vec[i]);
    end
  endgenerate

  // flag register; all flags come up clear
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags <= `EUI_FLAG_RESET;
    end else begin
      flags <= next_flags;
    end
  end

  // irq flop fed from next values, so it moves in the same cycle as
  // the flags and mask while still leaving the block from a register
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(next_flags & next_mask);
    end
  end
  assign irq = irq_q;

  // read mux; unmapped reads zero with pslverr
  always @* begin
    rdata = 32'h0;
    case (paddr)
      `EUI_STATUS_ADDR: begin
        rdata[`EUI_FLAG_HI:`EUI_FLAG_LO] = flags;
      end
      `EUI_MASK_ADDR: begin
        rdata[`EUI_FLAG_HI:`EUI_FLAG_LO] = mask;
      end
      `EUI_CTRL_ADDR: begin
        rdata = {30'h0, wdog_expired, wdog_enable};
      end
      default: begin
        rdata = 32'h0;
      end
    endcase
  end

  // read data launched at the setup edge and held through the access phase;
  // a flag set during the setup cycle shows on the following read
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0;
    end else if (psel && !penable && !pwrite) begin
      prdata_q <= rdata;
    end else begin
      prdata_q <= 32'h0;
    end
  end
  assign prdata = prdata_q;

endmodule

// two-flop synchroniser for one slow level pin
module eui_sync #(
  parameter [0:0] RST_LEVEL = 1'b0
) (
  input wire pclk,
  input wire presetn,
  input wire din,
  output wire dout
);

  // first stage is read only by the second stage
  reg [1:0] stages;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stages <= {2{RST_LEVEL}};
    end else begin
      stages <= {stages[0], din};
    end
  end
  assign dout = stages[1];

endmodule

// ---- hw/eui_map.vh ----
// register map, field positions and timing constants for the event flag block
// Function
// - set bit 23 when 8 ms watchdog expires
// - release mac reset after watchdog expiry, asynchronously
// - bit 23 latches a single pulse
// - set bit 22 on write into full fifo
// - discard rx data while overflow flag set
// - set bit 21 on transmitter error level
// - bit 20 holds while usb events pending
// - set bit 19 when tx path disabled
// - bit 19 follows either tx disabled bit
// - set bit 18 when rx path disabled
// - bit 18 follows either rx disabled bit
// - bit 17 reflects phy interrupt level
// - set bit 16 on data port completion
// - bit 16 latches a single pulse
`ifndef EUI_MAP_VH
`define EUI_MAP_VH
`define EUI_STATUS_ADDR 12'h000
`define EUI_MASK_ADDR 12'h004
`define EUI_CTRL_ADDR 12'h008
`define EUI_BIT_DP 16
`define EUI_BIT_PHY 17
`define EUI_BIT_RXDIS 18
`define EUI_BIT_TXDIS 19
`define EUI_BIT_USB 20
`define EUI_BIT_TXE 21
`define EUI_BIT_RDFO 22
`define EUI_BIT_MACRTO 23
`define EUI_FLAG_LO 16
`define EUI_FLAG_HI 23
`define EUI_FLAG_RESET 8'h00
`define EUI_MASK_RESET 8'h00
`define EUI_WDOG_MS 8
`define EUI_CLK_MHZ 100
`define EUI_WDOG_CYCLES (`EUI_WDOG_MS * 1000 * `EUI_CLK_MHZ)
`endif

// ---- tb/eui_flags_monitor.sv ----
// port-level assertions for the event flag block
`timescale 1ns/1ps
module eui_flags_monitor #(parameter integer WDOG_CYCLES = 20) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire pslverr,
  input wire irq,
  input wire phy_irq_n,
  input wire mac_reset_n,
  input wire rx_fifo_full,
  input wire rx_write_req,
  input wire rx_write_accept,
  input wire tx_error,
  input wire usb_event_pending,
  input wire fifo_tx_disabled,
  input wire mac_transmit_reg_disabled,
  input wire fifo_rx_disabled,
  input wire mac_receive_reg_disabled,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire [3:0] pstrb
);
  reg [7:0] m;
  wire acc = psel && penable;
  // shadow mask, so irq can be tied to its cause
  always @(posedge pclk or negedge presetn)
    if (!presetn) m <= 8'h00;
    else if (acc && pwrite && paddr == 12'h004 && pstrb[2]) m <= pwdata[23:16];
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  mask_gate_a: assert property (m == 8'h00 |-> !irq) else $error("irq unmasked");
  txe_irq_a: assert property (tx_error && m[5] |=> irq) else $error("txe irq");
  usb_irq_a: assert property (usb_event_pending && m[4] |=> irq) else $error("usb irq");
  tx_dis_a: assert property ((fifo_tx_disabled || mac_transmit_reg_disabled) && m[3] |=> irq)
    else $error("tx dis irq");
  rx_dis_a: assert property ((fifo_rx_disabled || mac_receive_reg_disabled) && m[2] |=> irq)
    else $error("rx dis irq");
  phy_irq_a: assert property ((!phy_irq_n && m[1]) [*4] |=> irq) else $error("phy irq");
  full_drop_a: assert property (rx_write_req && rx_fifo_full |=> !rx_write_accept)
    else $error("overflow accept");
  accept_ok_a: assert property (rx_write_accept |-> rx_write_req && !rx_fifo_full)
    else $error("bad accept");
  bad_addr_a: assert property (acc && paddr > 12'h008 |-> pslverr) else $error("no slverr");
  c_ovf: cover property (rx_write_req && rx_fifo_full);
  c_irq: cover property ($rose(irq));
  c_err: cover property (pslverr);
  c_mac_free: cover property ($rose(mac_reset_n));
endmodule
bind eui_flags eui_flags_monitor #(.WDOG_CYCLES(WDOG_CYCLES)) mon (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .pslverr(pslverr), .irq(irq), .phy_irq_n(phy_irq_n), .mac_reset_n(mac_reset_n),
  .rx_fifo_full(rx_fifo_full), .rx_write_req(rx_write_req),
  .rx_write_accept(rx_write_accept), .tx_error(tx_error),
  .usb_event_pending(usb_event_pending), .fifo_tx_disabled(fifo_tx_disabled),
  .mac_transmit_reg_disabled(mac_transmit_reg_disabled), .fifo_rx_disabled(fifo_rx_disabled),
  .mac_receive_reg_disabled(mac_receive_reg_disabled), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pstrb(pstrb)
);

// ---- tb/tb_eui_flags.sv ----
// self-checking bench for the event flag block
`timescale 1ns/1ps
module tb_eui_flags;
  reg pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, er;
  reg [11:0] paddr = 0;
  reg [31:0] pwdata = 0, rd;
  reg [3:0] pstrb = 4'hF;
  reg phy_rx_clk_seen = 0, rx_fifo_full = 0, rx_write_req = 0, tx_error = 0, dport_done = 0;
  reg usb_event_pending = 0, fifo_tx_disabled = 0, mac_transmit_reg_disabled = 0;
  reg fifo_rx_disabled = 0, mac_receive_reg_disabled = 0, phy_irq_n = 1;
  wire [31:0] prdata;
  wire pready, pslverr, rx_write_accept, mac_reset_n, irq;
  integer err_total = 0, comparisons = 0, i;
  always #5 pclk = ~pclk;
  // short watchdog count keeps the run brief
  eui_flags #(
    .WDOG_CYCLES(20)
  ) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .phy_rx_clk_seen(phy_rx_clk_seen), .rx_fifo_full(rx_fifo_full),
    .rx_write_req(rx_write_req), .rx_write_accept(rx_write_accept), .tx_error(tx_error),
    .usb_event_pending(usb_event_pending), .fifo_tx_disabled(fifo_tx_disabled),
    .mac_transmit_reg_disabled(mac_transmit_reg_disabled), .fifo_rx_disabled(fifo_rx_disabled),
    .mac_receive_reg_disabled(mac_receive_reg_disabled), .phy_irq_n(phy_irq_n), .dport_done(dport_done),
    .mac_reset_n(mac_reset_n), .irq(irq)
  );
  task ck(input ok);
    begin
      comparisons = comparisons + 1;
      if (!ok) begin
        err_total = err_total + 1;
        $display("[ERR] %0t compare failed", $time);
      end
    end
  endtask
  // one apb transfer, request held until pready is seen
  task apb(input w, input [11:0] a, input [31:0] d);
    begin
      psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk) penable <= 1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata; er = pslverr;
      psel <= 0; penable <= 0;
      @(posedge pclk);
    end
  endtask
  task print_verdict;
    begin
      if (err_total == 0 && comparisons > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
    end
  endtask
  task t_rst;
    begin
      apb(0, 12'h000, 0); ck(rd === 32'h0);
      apb(0, 12'h00C, 0); ck(er === 1'b1);
      ck(mac_reset_n === 1'b0);
      // phy clocks present release the mac after the two-flop sync
      phy_rx_clk_seen <= 1;
      repeat (3) @(posedge pclk);
      ck(mac_reset_n === 1'b1);
      phy_rx_clk_seen <= 0;
      repeat (3) @(posedge pclk);
      ck(mac_reset_n === 1'b0);
    end
  endtask
  // no phy clocks: watchdog must free the mac and latch one pulse
  task t_wdog;
    begin
      apb(1, 12'h008, 1);
      for (i = 0; i < 60 && mac_reset_n !== 1'b1; i = i + 1) @(posedge pclk);
      ck(mac_reset_n === 1'b1);
      apb(0, 12'h000, 0); ck(rd[23] === 1'b1);
      apb(1, 12'h000, 32'h0080_0000); apb(0, 12'h000, 0); ck(rd[23] === 1'b0);
    end
  endtask
  // level sources resist clearing while high
  task t_lvl;
    begin
      apb(1, 12'h004, 32'h00FF_0000);
      tx_error <= 1; usb_event_pending <= 1; fifo_tx_disabled <= 1; mac_receive_reg_disabled <= 1;
      phy_irq_n <= 0;
      apb(1, 12'h000, 32'h003E_0000); apb(0, 12'h000, 0);
      ck(rd[23:16] === 8'h3E);
      ck(irq === 1'b1);
      tx_error <= 0; usb_event_pending <= 0; fifo_tx_disabled <= 0; mac_receive_reg_disabled <= 0;
      phy_irq_n <= 1;
      repeat (4) @(posedge pclk);
      apb(1, 12'h000, 32'h003E_0000); apb(0, 12'h000, 0);
      ck(rd[23:16] === 8'h00);
      ck(irq === 1'b0);
      // the other source of each disabled pair
      mac_transmit_reg_disabled <= 1;
      fifo_rx_disabled <= 1;
      apb(1, 12'h000, 32'h000C_0000);
      apb(0, 12'h000, 0);
      ck(rd[23:16] === 8'h0C);
      mac_transmit_reg_disabled <= 0;
      fifo_rx_disabled <= 0;
      apb(1, 12'h000, 32'h000C_0000);
      apb(0, 12'h000, 0);
      ck(rd[23:16] === 8'h00);
    end
  endtask
  // write into full fifo, then data dropped until flag cleared
  task t_ovf;
    begin
      rx_fifo_full <= 1; rx_write_req <= 1;
      repeat (2) @(posedge pclk);
      rx_fifo_full <= 0;
      @(posedge pclk) ck(rx_write_accept === 1'b0);
      rx_write_req <= 0;
      apb(0, 12'h000, 0); ck(rd[22] === 1'b1);
      apb(1, 12'h000, 32'h0040_0000);
      rx_write_req <= 1;
      @(posedge pclk) ck(rx_write_accept === 1'b1);
      rx_write_req <= 0;
    end
  endtask
  task t_dp;
    begin
      dport_done <= 1;
      @(posedge pclk) dport_done <= 0;
      apb(0, 12'h000, 0); ck(rd[16] === 1'b1);
      // clear without byte lane 2 is ignored
      pstrb <= 4'h0;
      apb(1, 12'h000, 32'h0001_0000);
      pstrb <= 4'hF;
      apb(0, 12'h000, 0);
      ck(rd[16] === 1'b1);
      apb(1, 12'h000, 32'h0001_0000); apb(0, 12'h000, 0); ck(rd[16] === 1'b0);
      // a done level held high must not set the flag again after a clear
      dport_done <= 1;
      repeat (3) @(posedge pclk);
      apb(1, 12'h000, 32'h0001_0000);
      apb(0, 12'h000, 0);
      ck(rd[16] === 1'b0);
      dport_done <= 0;
    end
  endtask
  // hang guard, several times the roughly one hundred and fifteen cycles needed
  initial begin
    #10000;
    err_total = err_total + 1;
    print_verdict;
  end
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    t_rst; t_wdog; t_lvl; t_ovf; t_dp;
    print_verdict;
  end
endmodule
